/* File: rtl/smsp_clkdiv.sv */
`timescale 1ns/1ps
module smsp_clkdiv
#(
   parameter int             W = 8
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         run,
   input  wire logic [W-1:0] div,
   output logic              tick
);
   logic [W-1:0] cnt_q; // cycles into the half period

   // one tick every div+1 cycles while running
   assign tick = run & (cnt_q == div);

   // counter restarts whenever the engine stops
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= '0;
      else if (!run || tick)
         cnt_q <= '0;
      else
         cnt_q <= cnt_q + 1'b1;
   end
endmodule // smsp_clkdiv

/* File: rtl/smsp_pkg.sv */
package smsp_pkg;
   // register byte addresses
   localparam logic [31:0] SMSP_RX_ADDR   = 32'hffff0a04;
   localparam logic [31:0] SMSP_TX_ADDR   = 32'hffff0a08;
   localparam logic [31:0] SMSP_DIV_ADDR  = 32'hffff0a0c;
   localparam logic [31:0] SMSP_CTRL_ADDR = 32'hffff0a10;
   localparam logic [31:0] SMSP_STAT_ADDR = 32'hffff0a14;
   localparam logic [31:0] SMSP_MASK_ADDR = 32'hffff0a18;
   // reset values
   localparam logic [7:0]  SMSP_RX_RST    = 8'h00;
   localparam logic [7:0]  SMSP_TX_RST    = 8'h00;
   localparam logic [7:0]  SMSP_DIV_RST   = 8'h1b;
   localparam logic [15:0] SMSP_CTRL_RST  = 16'h0000;
   localparam logic [3:0]  SMSP_STAT_RST  = 4'h0;
   // writable control bits, reserved ones stay zero
   localparam logic [15:0] SMSP_CTRL_WMSK = 16'h1fef;
   // status bit positions
   localparam int          SMSP_ST_TXE    = 0;
   localparam int          SMSP_ST_RXF    = 1;
   localparam int          SMSP_ST_OVF    = 2;
   localparam int          SMSP_ST_UNF    = 3;
   // master interrupt gates: tx mode hides rx full, rx mode hides tx empty
   localparam logic [3:0]  SMSP_GATE_TX   = 4'hd;
   localparam logic [3:0]  SMSP_GATE_RX   = 4'he;
   // sixteenth serial clock edge closes a byte
   localparam logic [3:0]  SMSP_EDGE_LAST = 4'hf;
   // control register layout
   typedef struct packed {
      logic [2:0] rsv_hi;   // unused
      logic       cont;     // continuous transfer
      logic       loop;     // loopback
      logic       slv_oe;   // slave data output enable
      logic       ss_en;    // master select output enable
      logic       ovw;      // overwrite on overflow
      logic       unf_zero; // send zeros on underflow
      logic       tx_mode;  // start on transmit write
      logic       lsb;      // lsb first
      logic       rsv4;     // reserved
      logic       cpol;     // idle clock level
      logic       cpha;     // early clock pulse
      logic       master;   // master mode
      logic       en;       // port enable
   } smsp_ctrl_t;
   // serial pins as one bundle
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic mosi;
      logic miso;
   } smsp_pins_t;
   localparam logic [3:0]  SMSP_PINS_RST  = 4'h8;
   // engine states
   typedef enum logic [1:0] {
      SMSP_IDLE  = 2'b00,
      SMSP_SHIFT = 2'b01,
      SMSP_SLAVE = 2'b10
   } smsp_state_t;
endpackage

/* File: rtl/smsp_sync.sv */
`timescale 1ns/1ps
module smsp_sync
#(
   parameter int             W       = 4,
   parameter logic [W-1:0]   RST_VAL = '0
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   // two flops per bit; first stage feeds only the second
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         logic meta_q; // first stage
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_q <= RST_VAL[i];
               q[i]   <= RST_VAL[i];
            end
            else
            begin
               meta_q <= d[i];
               q[i]   <= meta_q;
            end
         end
      end
   endgenerate
endmodule // smsp_sync

/* File: rtl/smsp_top.sv */
`timescale 1ns/1ps
module smsp_top
   import smsp_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        NRST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [31:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        SCLK_I,
   output logic             SCLK_O,
   output logic             SCLK_OE,
   input  wire logic        MOSI_I,
   output logic             MOSI_O,
   output logic             MOSI_OE,
   input  wire logic        MISO_I,
   output logic             MISO_O,
   output logic             MISO_OE,
   input  wire logic        CS_N_I,
   output logic             CS_N_O,
   output logic             CS_N_OE,
   output logic             IRQ
);
   // reset release
   logic [1:0]  rst_sync_q;  // reset release chain
   wire         rst_n = rst_sync_q[1];

   // registers
   smsp_ctrl_t  ctrl_q;      // control
   logic [7:0]  div_q;       // clock divider
   logic [7:0]  tx_q;        // transmit byte
   logic        tx_full_q;   // transmit byte waiting
   logic [7:0]  last_tx_q;   // byte sent last
   logic [7:0]  rx_q;        // receive byte
   logic        rx_full_q;   // receive byte unread
   logic        rx_upd_q;    // receive byte stored last cycle
   logic [3:0]  stat_q;      // sticky events
   logic [3:0]  mask_q;      // interrupt mask
   logic        irq_q;       // interrupt level
   logic [31:0] prdata_q;    // read data

   // engine
   smsp_state_t state_q;     // engine state
   smsp_state_t state_d;     // next state
   logic [7:0]  tx_sh_q;     // outgoing shifter
   logic [7:0]  rx_sh_q;     // incoming shifter
   logic        out_q;       // bit on the data output
   logic [3:0]  ecnt_q;      // serial clock edges in this byte
   logic        sclk_q;      // master clock level
   logic        cs_n_q;      // master select level
   logic        sclk_d_q;    // slave clock, last cycle
   logic        cs_d_q;      // slave select, last cycle
   smsp_pins_t  pins_s;      // synchronised pins
   logic        tick;        // master half period

   // reset: asserted at once, released after two edges
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
         rst_sync_q <= 2'b00;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end

   // pins cross into the core clock through two flops
   smsp_sync #(
      .W       (4),
      .RST_VAL (SMSP_PINS_RST)
   ) u_sync (
      .clk   (CLOCK),
      .rst_n (rst_n),
      .d     ({CS_N_I, SCLK_I, MOSI_I, MISO_I}),
      .q     (pins_s)
   );

   // master half period generator
   smsp_clkdiv #(
      .W (8)
   ) u_div (
      .clk   (CLOCK),
      .rst_n (rst_n),
      .run   (state_q == SMSP_SHIFT),
      .div   (div_q),
      .tick  (tick)
   );

   // bus decode
   wire setup    = PSEL & ~PENABLE;
   wire access   = PSEL & PENABLE;
   wire hit_rx   = PADDR == SMSP_RX_ADDR;
   wire hit_tx   = PADDR == SMSP_TX_ADDR;
   wire hit_div  = PADDR == SMSP_DIV_ADDR;
   wire hit_ctrl = PADDR == SMSP_CTRL_ADDR;
   wire hit_stat = PADDR == SMSP_STAT_ADDR;
   wire hit_mask = PADDR == SMSP_MASK_ADDR;
   wire mapped   = hit_rx | hit_tx | hit_div | hit_ctrl | hit_stat | hit_mask;
   wire wr       = access & PWRITE;
   wire rd_rx    = access & ~PWRITE & hit_rx;
   wire wr_tx    = wr & hit_tx;
   wire wr_div   = wr & hit_div;
   wire wr_ctrl  = wr & hit_ctrl;
   wire wr_stat  = wr & hit_stat;
   wire wr_mask  = wr & hit_mask;
   // a byte stored between setup and access keeps its flag
   wire rd_clr   = rd_rx & ~rx_upd_q;

   // read selection; transmit reads as zero
   wire [31:0] rdata_d =
      hit_rx   ? {24'h0, rx_q}   :
      hit_div  ? {24'h0, div_q}  :
      hit_ctrl ? {16'h0, ctrl_q} :
      hit_stat ? {28'h0, stat_q} :
      hit_mask ? {28'h0, mask_q} : 32'h0;

   assign PRDATA  = prdata_q;
   assign PREADY  = 1'b1;
   assign PSLVERR = access & ~mapped;

   // mode decode
   wire m_on     = ctrl_q.en & ctrl_q.master;
   wire s_on     = ctrl_q.en & ~ctrl_q.master;
   wire in_idle  = state_q == SMSP_IDLE;
   wire in_shift = state_q == SMSP_SHIFT;
   wire in_slave = state_q == SMSP_SLAVE;

   // slave edges seen on the synchronised pins
   wire cs_sel   = ~pins_s.cs_n;
   wire cs_fall  = cs_sel & cs_d_q;
   wire s_rise   = pins_s.sclk & ~sclk_d_q;
   wire s_fall   = ~pins_s.sclk & sclk_d_q;
   wire s_lead   = ctrl_q.cpol ? s_fall : s_rise;
   wire s_trail  = ctrl_q.cpol ? s_rise : s_fall;

   // leading and trailing edges of either role
   wire lead_e   = in_shift ? tick & ~ecnt_q[0] : in_slave & cs_sel & s_lead;
   wire trail_e  = in_shift ? tick & ecnt_q[0] : in_slave & cs_sel & s_trail;
   // early pulse launches on leading, samples on trailing
   wire sample_e = ctrl_q.cpha ? trail_e : lead_e;
   wire launch_e = ctrl_q.cpha ? lead_e : trail_e;
   wire end_e    = trail_e & (ecnt_q == SMSP_EDGE_LAST);

   // transfer starts
   wire m_start  = in_idle & m_on & (ctrl_q.tx_mode ? tx_full_q : rd_rx);
   wire m_more   = in_shift & end_e & ctrl_q.cont & tx_full_q;
   wire s_load   = in_slave & s_on & (cs_fall | (end_e & cs_sel));
   wire ld       = m_start | m_more | s_load;

   // next outgoing byte, with underflow policy
   wire [7:0] tx_pick = tx_full_q       ? tx_q :
                        ctrl_q.unf_zero ? 8'h00 : last_tx_q;

   // incoming bit, looped from own output when testing
   wire rx_in = ctrl_q.loop    ? out_q :
                ctrl_q.master  ? pins_s.miso : pins_s.mosi;
   wire [7:0] rx_shift = ctrl_q.lsb ? {rx_in, rx_sh_q[7:1]} : {rx_sh_q[6:0], rx_in};
   // early pulse samples the last bit on the closing edge itself
   wire [7:0] rx_byte  = ctrl_q.cpha ? rx_shift : rx_sh_q;
   // store unless a full register is protected
   wire st = end_e & (~rx_full_q | ctrl_q.ovw | rd_clr);

   // events
   logic [3:0] ev; // one-cycle event pulses
   assign ev[SMSP_ST_TXE] = ld & tx_full_q;
   assign ev[SMSP_ST_RXF] = st;
   assign ev[SMSP_ST_OVF] = end_e & ~st;
   assign ev[SMSP_ST_UNF] = ld & ~tx_full_q;
   wire [3:0] w1c  = wr_stat ? PWDATA[3:0] : 4'h0;
   // master mode hides rx full in tx mode and tx empty in rx mode
   wire [3:0] gate = ~m_on ? 4'hf :
                     ctrl_q.tx_mode ? SMSP_GATE_TX : SMSP_GATE_RX;

   // first bit and shift of a byte in the chosen order
   function automatic logic first_bit(input logic [7:0] b, input logic lsb);
      first_bit = lsb ? b[0] : b[7];
   endfunction
   function automatic logic [7:0] shift_out(input logic [7:0] b, input logic lsb);
      shift_out = lsb ? {1'b0, b[7:1]} : {b[6:0], 1'b0};
   endfunction

   // state sequencing
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         SMSP_IDLE:
         begin
            if (m_start)
               state_d = SMSP_SHIFT;
            else if (s_on)
               state_d = SMSP_SLAVE;
         end
         SMSP_SHIFT:
         begin
            // drop out when disabled or the byte run ends
            if (!m_on)
               state_d = SMSP_IDLE;
            else if (end_e && !m_more)
               state_d = SMSP_IDLE;
         end
         SMSP_SLAVE:
         begin
            if (!s_on)
               state_d = SMSP_IDLE;
         end
         default:
            state_d = SMSP_IDLE;
      endcase
   end

   // state, select and clock levels
   always_ff @(posedge CLOCK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= SMSP_IDLE;
         cs_n_q  <= 1'b1;
         sclk_q  <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cs_n_q  <= state_d != SMSP_SHIFT;
         if (!in_shift)
            sclk_q <= ctrl_q.cpol;
         else if (tick)
            sclk_q <= ~sclk_q;
      end
   end

   // edge count and slave edge history
   always_ff @(posedge CLOCK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ecnt_q   <= 4'h0;
         sclk_d_q <= 1'b0;
         cs_d_q   <= 1'b1;
      end
      else
      begin
         sclk_d_q <= pins_s.sclk;
         cs_d_q   <= pins_s.cs_n;
         if (ld || in_idle || (in_slave && !cs_sel))
            ecnt_q <= 4'h0;
         else if (lead_e || trail_e)
            ecnt_q <= ecnt_q + 4'h1;
      end
   end

   // shifters: a load beats a launch in the same cycle
   always_ff @(posedge CLOCK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_sh_q <= 8'h00;
         rx_sh_q <= 8'h00;
         out_q   <= 1'b0;
      end
      else
      begin
         if (ld)
         begin
            // late pulse needs the first bit before any edge
            tx_sh_q <= ctrl_q.cpha ? tx_pick : shift_out(tx_pick, ctrl_q.lsb);
            if (!ctrl_q.cpha)
               out_q <= first_bit(tx_pick, ctrl_q.lsb);
         end
         else if (launch_e)
         begin
            out_q   <= first_bit(tx_sh_q, ctrl_q.lsb);
            tx_sh_q <= shift_out(tx_sh_q, ctrl_q.lsb);
         end
         if (sample_e)
            rx_sh_q <= rx_shift;
      end
   end

   // transmit holding register
   always_ff @(posedge CLOCK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_q      <= SMSP_TX_RST;
         tx_full_q <= 1'b0;
         last_tx_q <= SMSP_TX_RST;
      end
      else
      begin
         if (wr_tx)
            tx_q <= PWDATA[7:0];
         // a write in the cycle of a load keeps the flag set
         tx_full_q <= wr_tx | (tx_full_q & ~ld);
         if (ld)
            last_tx_q <= tx_pick;
      end
   end

   // receive register
   always_ff @(posedge CLOCK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_q      <= SMSP_RX_RST;
         rx_full_q <= 1'b0;
         rx_upd_q  <= 1'b0;
      end
      else
      begin
         if (st)
            rx_q <= rx_byte;
         // store wins over the clearing read
         rx_full_q <= st | (rx_full_q & ~rd_clr);
         rx_upd_q  <= st;
      end
   end

   // software registers
   always_ff @(posedge CLOCK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_q   <= SMSP_CTRL_RST;
         div_q    <= SMSP_DIV_RST;
         mask_q   <= SMSP_STAT_RST;
         stat_q   <= SMSP_STAT_RST;
         irq_q    <= 1'b0;
         prdata_q <= 32'h0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_q <= PWDATA[15:0] & SMSP_CTRL_WMSK;
         if (wr_div)
            div_q <= PWDATA[7:0];
         if (wr_mask)
            mask_q <= PWDATA[3:0];
         // new events win over a write-one clear
         stat_q <= (stat_q & ~w1c) | ev;
         irq_q  <= |(stat_q & mask_q & gate);
         if (setup)
            prdata_q <= rdata_d;
      end
   end

   // pin drive
   assign SCLK_O  = sclk_q;
   assign SCLK_OE = m_on;
   assign MOSI_O  = out_q;
   assign MOSI_OE = m_on;
   assign MISO_O  = out_q;
   assign MISO_OE = s_on & ctrl_q.slv_oe & cs_sel;
   assign CS_N_O  = cs_n_q;
   assign CS_N_OE = m_on & ctrl_q.ss_en;
   assign IRQ     = irq_q;

   // checks
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!rst_n);

   chk_disable_idle: assert property (
      !ctrl_q.en |=> state_q == SMSP_IDLE)
      else $error("engine active while disabled");
   chk_idle_clock: assert property (
      in_idle && $past(in_idle) && $stable(ctrl_q) |-> SCLK_O == ctrl_q.cpol)
      else $error("idle clock level wrong");
   chk_tx_start: assert property (
      in_idle && m_on && ctrl_q.tx_mode && tx_full_q |=> in_shift && !CS_N_O)
      else $error("transmit write did not start transfer");
   chk_lsb_first: assert property (
      ld && !ctrl_q.cpha |=> out_q == $past(ctrl_q.lsb ? tx_pick[0] : tx_pick[7]))
      else $error("first bit order wrong");
   chk_rx_drop: assert property (
      end_e && rx_full_q && !ctrl_q.ovw && !rd_clr |=> rx_q == $past(rx_q))
      else $error("protected receive byte overwritten");
   chk_single_byte: assert property (
      in_shift && end_e && !ctrl_q.cont |=> in_idle && CS_N_O)
      else $error("single byte did not end");
   chk_slave_oe: assert property (
      MISO_OE |-> ctrl_q.slv_oe && !ctrl_q.master && ctrl_q.en)
      else $error("slave output driven while disabled");
   chk_div_reset: assert property (
      $rose(rst_n) |-> div_q == SMSP_DIV_RST && ctrl_q == SMSP_CTRL_RST)
      else $error("divider or control reset value wrong");
   chk_irq_level: assert property (
      IRQ |-> $past(|(stat_q & mask_q & gate)))
      else $error("interrupt without unmasked event");

   cov_master_byte: cover property (in_shift && end_e ##1 in_idle);
   cov_slave_byte:  cover property (in_slave && st);
   cov_overflow:    cover property (ev[SMSP_ST_OVF]);
   cov_continuous:  cover property (m_more);
endmodule // smsp_top

/* File: test/smsp_peer.sv */
`timescale 1ns/1ps
module smsp_peer
(
   input  wire logic       clk,
   input  wire logic       sclk,
   input  wire logic       cs_n,
   input  wire logic       mosi,
   input  wire logic       cpol,
   input  wire logic       cpha,
   input  wire logic       lsb,
   input  wire logic [7:0] tx_byte,
   output logic            miso,
   output logic      [7:0] rx_byte,
   output logic      [5:0] edges
);
   logic       sclk_q; // serial clock seen last cycle
   logic       cs_q;   // select seen last cycle
   logic [2:0] idx;    // bit slot of the current edge

   // bit position of a slot, following the chosen order
   function automatic logic [2:0] pos(input logic [2:0] i);
      return lsb ? i : 3'h7 - i;
   endfunction

   // start quiet
   initial
   begin
      sclk_q  = 1'b0;
      cs_q    = 1'b1;
      miso    = 1'b0;
      rx_byte = 8'h00;
      edges   = 6'h00;
   end

   // peer slave clocked by the master's serial clock, oversampled on the core clock
   always @(posedge clk)
   begin
      sclk_q <= sclk;
      cs_q   <= cs_n;
      if (!cs_q && sclk != sclk_q)
      begin
         // edge inside the frame; the closing edge may meet the select release
         idx = edges[3:1];
         if ((sclk != cpol) ^ cpha)
            rx_byte[pos(idx)] <= mosi;
         else
            miso <= tx_byte[pos(cpha ? idx : idx + 3'h1)];
         edges <= edges + 6'h01;
      end
      else if (cs_n)
         // released line toggles so no stale bit can pass for data
         miso <= ~miso;
      else if (cs_q)
      begin
         // select fall opens a frame with the first bit
         miso  <= tx_byte[pos(3'h0)];
         edges <= 6'h00;
      end
   end
endmodule // smsp_peer

/* File: test/smsp_top_tb.sv */
`timescale 1ns/1ps
module smsp_top_tb;
   import smsp_pkg::*;
   logic        clk;                               // core clock
   logic        nrst;                              // reset, active low
   logic        psel, penable, pwrite, pready, err; // bus controls
   logic [31:0] paddr, pwdata, prdata, rd;         // bus data
   logic        sclk_o, sclk_oe, mosi_o, mosi_oe;  // master pins
   logic        miso_o, miso_oe, cs_o, cs_oe, irq; // slave pins and irq
   logic        cs_i, cs_w, miso_w, peer_miso;     // wires
   logic        sclk_i, mosi_i;                    // slave port drive
   logic [7:0]  peer_tx, peer_rx, b, m;            // bytes
   logic [5:0]  peer_edges;                        // edges seen by peer
   logic [15:0] lf;                                // random state
   smsp_ctrl_t  cfg;                               // control image
   int          err_count, n_tests;

   // wire levels: select has a pull-up, data in comes from whoever drives
   assign cs_w   = cs_oe ? cs_o : 1'b1;
   assign miso_w = miso_oe ? miso_o : peer_miso;

   smsp_top smsp_top_i (.CLOCK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(err), .SCLK_I(sclk_i), .SCLK_O(sclk_o), .SCLK_OE(sclk_oe), .MOSI_I(mosi_i),
      .MOSI_O(mosi_o), .MOSI_OE(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o),
      .MISO_OE(miso_oe), .CS_N_I(cs_i), .CS_N_O(cs_o), .CS_N_OE(cs_oe), .IRQ(irq));

   smsp_peer smsp_peer_i (.clk(clk), .sclk(sclk_o), .cs_n(cs_w), .mosi(mosi_o),
      .cpol(cfg.cpol), .cpha(cfg.cpha), .lsb(cfg.lsb), .tx_byte(peer_tx),
      .miso(peer_miso), .rx_byte(peer_rx), .edges(peer_edges));

   // 25 ns core clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // next random word
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // compare and count
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // verdict and end of run
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // one bus transfer, setup then access until ready
   task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d);
      int k;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (k >= 20)
      begin
         err_count++;
         close_out();
      end
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // wait for one framed transfer to start and finish
   task automatic wait_cs();
      int k;
      k = 0;
      while (cs_w !== 1'b0 && k < 3000)
      begin
         @(posedge clk);
         k++;
      end
      while (cs_w !== 1'b1 && k < 3000)
      begin
         @(posedge clk);
         k++;
      end
      if (k >= 3000)
      begin
         err_count++;
         close_out();
      end
      // let the peer take the closing edge
      @(posedge clk);
   endtask

   // new random byte pair
   task automatic roll();
      lf = lfsr(lf);
      b  = lf[7:0];
      lf = lfsr(lf);
      m  = lf[15:8];
   endtask

   // master send of b while the peer answers m
   task automatic xfer();
      peer_tx <= m;
      apb(SMSP_TX_ADDR, 1'b1, {24'h0, b});
      wait_cs();
      chk("peer rx", {24'h0, b}, {24'h0, peer_rx});
      chk("edges", 32'h10, {26'h0, peer_edges});
   endtask

   task automatic set();
      apb(SMSP_CTRL_ADDR, 1'b1, {16'h0, cfg});
   endtask

   // external master byte on the slave port: mode 0, msb first, slow clock
   task automatic sbyte(input logic [7:0] d);
      rd = '0;
      for (int j = 7; j >= 0; j--)
      begin
         mosi_i <= d[j];
         repeat (4) @(posedge clk);
         rd[j] = miso_o;
         sclk_i <= 1'b1;
         repeat (4) @(posedge clk);
         sclk_i <= 1'b0;
      end
      repeat (4) @(posedge clk);
   endtask

   initial
   begin
      nrst = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {cs_i, sclk_i, mosi_i} = 3'b100;
      peer_tx = 8'h00;
      cfg = '0;
      lf = 16'd48268;
      err_count = 0;
      n_tests = 0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      // reset values, access kinds, unmapped place
      apb(SMSP_DIV_ADDR, 1'b0, 0);
      chk("div", 32'h1b, rd);
      apb(SMSP_CTRL_ADDR, 1'b0, 0);
      chk("ctrl", 32'h0, rd);
      apb(SMSP_RX_ADDR, 1'b1, 32'h5a);
      apb(SMSP_RX_ADDR, 1'b0, 0);
      chk("rx", 32'h0, rd);
      apb(SMSP_TX_ADDR, 1'b0, 0);
      chk("tx read", 32'h0, rd);
      apb(SMSP_CTRL_ADDR, 1'b1, 32'hffff);
      apb(SMSP_CTRL_ADDR, 1'b0, 0);
      chk("ctrl bits", 32'h1fef, rd);
      psel <= 1'b1;
      paddr <= 32'hffff0a40;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      chk("unmapped", 32'h1, {31'h0, err});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      $display("test registers done");
      // every clock mode and order in master transmit mode
      for (int i = 0; i < 8; i++)
      begin
         cfg = '0;
         {cfg.en, cfg.master, cfg.tx_mode, cfg.ss_en} = 4'hf;
         {cfg.lsb, cfg.cpol, cfg.cpha} = i[2:0];
         set();
         roll();
         apb(SMSP_DIV_ADDR, 1'b1, {30'h0, lf[1:0]} + 32'h3);
         xfer();
         chk("idle clock", {31'h0, cfg.cpol}, {31'h0, sclk_o});
         chk("select oe", 32'h1, {31'h0, cs_oe});
         apb(SMSP_RX_ADDR, 1'b0, 0);
         chk("rx", {24'h0, m}, rd);
      end
      $display("test master modes done");
      // receive mode: a read starts the byte, underflow resends or sends zero
      cfg.tx_mode = 1'b0;
      for (int u = 0; u < 2; u++)
      begin
         cfg.unf_zero = u[0];
         set();
         apb(SMSP_RX_ADDR, 1'b0, 0);
         wait_cs();
         chk("underflow", u ? 32'h0 : {24'h0, b}, {24'h0, peer_rx});
      end
      $display("test underflow done");
      // overflow: drop or overwrite the unread byte
      cfg.tx_mode = 1'b1;
      for (int o = 0; o < 2; o++)
      begin
         cfg.ovw = o[0];
         set();
         apb(SMSP_STAT_ADDR, 1'b1, 32'hf);
         apb(SMSP_RX_ADDR, 1'b0, 0);
         roll();
         xfer();
         m = ~m;
         xfer();
         apb(SMSP_RX_ADDR, 1'b0, 0);
         chk("overflow rx", {24'h0, o ? m : ~m}, rd);
         apb(SMSP_STAT_ADDR, 1'b0, 0);
         chk("overflow flag", {31'h0, ~o[0]}, {31'h0, rd[SMSP_ST_OVF]});
      end
      $display("test overflow done");
      // continuous: two queued bytes under one select
      cfg.cont = 1'b1;
      set();
      roll();
      peer_tx <= m;
      apb(SMSP_TX_ADDR, 1'b1, {24'h0, m});
      apb(SMSP_TX_ADDR, 1'b1, {24'h0, b});
      wait_cs();
      chk("cont edges", 32'h20, {26'h0, peer_edges});
      chk("cont byte", {24'h0, b}, {24'h0, peer_rx});
      cfg.cont = 1'b0;
      set();
      $display("test continuous done");
      // interrupt: masked, raised, cleared, hidden by mode
      apb(SMSP_STAT_ADDR, 1'b1, 32'hf);
      apb(SMSP_MASK_ADDR, 1'b1, 32'h0);
      roll();
      xfer();
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(SMSP_MASK_ADDR, 1'b1, 32'h1);
      @(posedge clk);
      chk("irq set", 32'h1, {31'h0, irq});
      apb(SMSP_STAT_ADDR, 1'b1, 32'h1);
      @(posedge clk);
      chk("irq clear", 32'h0, {31'h0, irq});
      apb(SMSP_MASK_ADDR, 1'b1, 32'h2);
      @(posedge clk);
      chk("irq gated", 32'h0, {31'h0, irq});
      $display("test interrupt done");
      // loopback returns own byte
      cfg.loop = 1'b1;
      set();
      roll();
      xfer();
      apb(SMSP_RX_ADDR, 1'b0, 0);
      chk("loop rx", {24'h0, b}, rd);
      // disable in mid byte, then select output off
      cfg.loop = 1'b0;
      cfg.cpol = 1'b1;
      set();
      apb(SMSP_TX_ADDR, 1'b1, {24'h0, m});
      cfg.en = 1'b0;
      set();
      repeat (2) @(posedge clk);
      chk("abort clock", 32'h1, {31'h0, sclk_o});
      chk("abort oe", 32'h0, {30'h0, sclk_oe, cs_oe});
      {cfg.en, cfg.ss_en} = 2'b10;
      set();
      chk("no select", 32'h0, {31'h0, cs_oe});
      $display("test abort done");
      // slave: data output only when allowed
      cfg = '0;
      {cfg.en, cfg.slv_oe} = 2'b11;
      set();
      apb(SMSP_TX_ADDR, 1'b1, {24'h0, b});
      cs_i <= 1'b0;
      repeat (6) @(posedge clk);
      chk("slave oe", 32'h1, {31'h0, miso_oe});
      chk("slave clk", 32'h0, {31'h0, sclk_oe});
      sbyte(m);
      chk("slave tx", {24'h0, b}, rd);
      apb(SMSP_RX_ADDR, 1'b0, 0);
      chk("slave rx", {24'h0, m}, rd);
      cfg.slv_oe = 1'b0;
      set();
      repeat (6) @(posedge clk);
      chk("slave off", 32'h0, {31'h0, miso_oe});
      $display("test slave done");
      close_out();
   end
endmodule // smsp_top_tb
